// [hdl/throttle_pkg.sv]
/*
  Shared constants for the activation throttle: register offsets, field
  positions, reset values, window lengths and limit encodings.
  Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
*/
package throttle_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 10;

  // Register byte offsets
  localparam logic [7:0] LOW_LIMIT_OFS       = 8'h64;
  localparam logic [7:0] STATUS_OFS          = 8'h68;
  localparam logic [7:0] CONTROL_OFS         = 8'h6C;
  localparam logic [7:0] GLOBAL_LIMIT_OFS    = 8'h70;
  localparam logic [7:0] MID_LIMIT_OFS       = 8'h74;
  localparam logic [7:0] IRQ_STATUS_OFS      = 8'h78;
  localparam logic [7:0] IRQ_MASK_OFS        = 8'h7C;

  // Field positions
  localparam int unsigned STS_GLOBAL_BIT     = 8;
  localparam int unsigned CTRL_HUNT_BIT      = 0;
  localparam int unsigned CTRL_DEBUG_BIT     = 1;
  localparam int unsigned IRQ_ENGAGE_BIT     = 0;
  localparam int unsigned IRQ_RELEASE_BIT    = 1;
  localparam int unsigned IRQ_BITS           = 2;

  // Reset values
  localparam logic [7:0] LIMIT_RESET         = 8'h00;
  localparam logic [1:0] IRQ_RESET           = 2'h0;

  // Limit encodings
  localparam logic [7:0] LIMIT_MAX           = 8'hA8;
  localparam int unsigned ACT_PER_STEP_SHIFT = 2;
  localparam int unsigned GLB_UNIT_SHIFT     = 16;
  localparam int unsigned GLB_DBG_UNIT_SHIFT = 4;

  // Window lengths in cycles
  localparam int unsigned GLB_WINDOW_BASE    = 1344;
  localparam int unsigned GLB_WINDOW_MULT    = 16384;
  localparam int unsigned GLB_DBG_MULT       = 4;
  localparam int unsigned GLB_WINDOW_CYCLES  = GLB_WINDOW_MULT * GLB_WINDOW_BASE;
  localparam int unsigned GLB_DBG_CYCLES     = GLB_DBG_MULT * GLB_WINDOW_BASE;
  localparam int unsigned ACT_WINDOW_CYCLES  = 1344;

  // Quiet windows needed before release
  localparam logic [4:0] QUIET_NORMAL        = 5'h10;
  localparam logic [4:0] QUIET_DEBUG         = 5'h02;

  // Temperature ranges
  localparam logic [1:0] TEMP_LOW            = 2'h0;
  localparam logic [1:0] TEMP_MID            = 2'h1;

  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;

endpackage

// [hdl/window_timer.sv]
/*
  Free-running window timer that pulses once per window.
  Assumes len_i is at least one and stays stable over most windows.
*/
`timescale 1ns/1ps
module window_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] len_i,
  output logic             tick_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } state_t;

  state_t st_reg;
  state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    // Compare with >= so a shortened length ends the window at once
    if (st_reg.cnt >= len_i - 32'h0000_0001) begin
      st_next.cnt = 32'h0000_0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;

endmodule

// [hdl/pair_limiter.sv]
/*
  Per module pair activate counting for the activation window and the
  global window. Assumes act_i is a granted activate on this pair.
*/
`timescale 1ns/1ps
module pair_limiter (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        act_i,
  input  wire logic        act_tick_i,
  input  wire logic        glb_tick_i,
  input  wire logic [7:0]  thr_val_i,
  input  wire logic        glb_on_i,
  input  wire logic [31:0] glb_thresh_i,
  output logic             block_o,
  output logic             exceed_o
);

  typedef struct packed {
    logic [9:0]  act_cnt;
    logic [31:0] glb_cnt;
    logic        block;
  } state_t;

  state_t      st_reg;
  state_t      st_next;
  logic [31:0] glb_sum;
  logic [9:0]  act_cap;
  logic [9:0]  act_sum;

  always_comb begin
    st_next = st_reg;
    // Tick cycle opens the new window, so its activate counts there
    glb_sum = (glb_tick_i ? 32'h0000_0000 : st_reg.glb_cnt) + {31'h0000_0000, act_i};
    act_sum = (act_tick_i ? 10'h000 : st_reg.act_cnt) + {9'h000, act_i};
    act_cap = {thr_val_i, 2'h0};
    st_next.glb_cnt = glb_sum;
    st_next.act_cnt = act_sum;
    st_next.block = (thr_val_i != 8'h00) && (act_sum >= act_cap);
  end

  // Unregistered so the throttle choice sees this cycle's activates
  assign exceed_o = glb_on_i && (glb_sum > glb_thresh_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Old window's block must not eat the new window's first cycle
  assign block_o = st_reg.block && !act_tick_i;

endmodule

// [hdl/dram_activation_throttle.sv]
/*
  Activation throttle: global open-loop detector, throttle value selection,
  per pair activate limiting and the AXI4-Lite register file.
  Assumes temp_range_i and act_req_i come from logic on clk_i.
*/
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module dram_activation_throttle #(
  parameter int unsigned NUM_PAIRS      = 2,
  parameter int unsigned GLB_WINDOW_LEN = throttle_pkg::GLB_WINDOW_CYCLES,
  parameter int unsigned GLB_DEBUG_LEN  = throttle_pkg::GLB_DBG_CYCLES,
  parameter int unsigned ACT_WINDOW_LEN = throttle_pkg::ACT_WINDOW_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [7:0]           s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire logic [1:0]           temp_range_i,
  input  wire logic [NUM_PAIRS-1:0] act_req_i,
  output logic [NUM_PAIRS-1:0]      act_grant_o,
  output logic                      global_throttle_active_o,
  output logic                      irq_o
);

  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 arready;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [7:0]           low_limit_value;
    logic [7:0]           mid_limit_value;
    logic [7:0]           global_activation_limit;
    logic                 thermal_hunt_enable;
    logic                 global_window_debug_select;
    logic                 global_throttle_active;
    logic                 window_hit;
    logic [4:0]           quiet_cnt;
    logic [7:0]           current_throttle_value;
    logic [1:0]           irq_status;
    logic [1:0]           irq_mask;
    logic                 irq;
    logic [NUM_PAIRS-1:0] grant;
  } state_t;

  state_t               st_reg;
  state_t               st_next;
  logic                 act_tick;
  logic                 glb_tick;
  logic [31:0]          glb_len;
  logic [31:0]          glb_thresh;
  logic                 glb_on;
  logic [NUM_PAIRS-1:0] pair_block;
  logic [NUM_PAIRS-1:0] pair_exceed;
  logic [NUM_PAIRS-1:0] pair_act;
  logic                 any_exceed;
  logic                 global_throttle_comb;
  logic [7:0]           thr_sel;
  logic [4:0]           quiet_need;
  logic                 do_write;
  logic                 release_now;
  logic [7:0]           wbyte;
  logic [1:0]           irq_set;

  // Global window length follows the debug select directly; the activation window length is fixed
  assign glb_len = st_reg.global_window_debug_select ? GLB_DEBUG_LEN : GLB_WINDOW_LEN;

  // Debug windows are 4096 times shorter, so the unit shrinks with them
  always_comb begin
    glb_thresh = 32'h0000_0000;
    if (st_reg.global_window_debug_select) begin
      glb_thresh[8+throttle_pkg::GLB_DBG_UNIT_SHIFT-1:0] =
        {st_reg.global_activation_limit, 4'h0};
    end else begin
      glb_thresh[8+throttle_pkg::GLB_UNIT_SHIFT-1:0] =
        {st_reg.global_activation_limit, 16'h0000};
    end
  end

  assign glb_on = (st_reg.global_activation_limit != 8'h00);

  window_timer u_act_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .len_i  (ACT_WINDOW_LEN),
    .tick_o (act_tick)
  );

  window_timer u_glb_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .len_i  (glb_len),
    .tick_o (glb_tick)
  );

  genvar p;
  generate
    for (p = 0; p < NUM_PAIRS; p++) begin : g_pair
      assign pair_act[p] = act_req_i[p] && !pair_block[p];
      pair_limiter u_pair (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .act_i        (pair_act[p]),
        .act_tick_i   (act_tick),
        .glb_tick_i   (glb_tick),
        .thr_val_i    (st_reg.current_throttle_value),
        .glb_on_i     (glb_on),
        .glb_thresh_i (glb_thresh),
        .block_o      (pair_block[p]),
        .exceed_o     (pair_exceed[p])
      );
    end
  endgenerate

  assign any_exceed = |pair_exceed;

  // Latched flag alone lags a cycle; the live exceed closes that gap
  assign global_throttle_comb = st_reg.global_throttle_active || any_exceed;

  // Throttle value selection
  always_comb begin
    if (global_throttle_comb) begin
      thr_sel = st_reg.mid_limit_value;
    end else if (!st_reg.thermal_hunt_enable) begin
      thr_sel = st_reg.low_limit_value;
    end else if (temp_range_i == throttle_pkg::TEMP_LOW) begin
      thr_sel = st_reg.low_limit_value;
    end else begin
      // High range falls back on mid; the high limit is not built here
      thr_sel = st_reg.mid_limit_value;
    end
  end

  assign quiet_need = st_reg.global_window_debug_select ?
                      throttle_pkg::QUIET_DEBUG : throttle_pkg::QUIET_NORMAL;

  assign release_now = glb_tick && st_reg.global_throttle_active && !st_reg.window_hit &&
                       !any_exceed && (st_reg.quiet_cnt + 5'h01 >= quiet_need);

  assign do_write = !st_reg.awready && !st_reg.wready && !st_reg.bvalid;
  assign wbyte = st_reg.w_data[7:0];

  always_comb begin
    irq_set = 2'h0;
    irq_set[throttle_pkg::IRQ_ENGAGE_BIT] = any_exceed && !st_reg.global_throttle_active;
    irq_set[throttle_pkg::IRQ_RELEASE_BIT] = release_now;
  end

  always_comb begin
    st_next = st_reg;
    st_next.grant = pair_act;
    st_next.current_throttle_value = thr_sel;

    // Global detector
    if (any_exceed) begin
      st_next.global_throttle_active = 1'b1;
    end else if (release_now) begin
      st_next.global_throttle_active = 1'b0;
    end
    if (glb_tick) begin
      st_next.window_hit = 1'b0;
      if (st_reg.window_hit || any_exceed || release_now) begin
        st_next.quiet_cnt = 5'h00;
      end else if (st_reg.quiet_cnt != 5'h1F) begin
        st_next.quiet_cnt = st_reg.quiet_cnt + 5'h01;
      end
    end else if (any_exceed) begin
      st_next.window_hit = 1'b1;
    end

    // Write address and data taken in either order
    if (st_reg.awready && s_axi_awvalid_i) begin
      st_next.awready = 1'b0;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (st_reg.wready && s_axi_wvalid_i) begin
      st_next.wready = 1'b0;
      st_next.w_data = s_axi_wdata_i;
      st_next.w_strb = s_axi_wstrb_i;
    end
    if (do_write) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = throttle_pkg::RESP_OKAY;
      case ({st_reg.aw_addr[7:2], 2'h0})
        throttle_pkg::LOW_LIMIT_OFS: begin
          if (st_reg.w_strb[0]) begin
            st_next.low_limit_value = (wbyte > throttle_pkg::LIMIT_MAX) ?
                                      throttle_pkg::LIMIT_MAX : wbyte;
          end
        end
        throttle_pkg::MID_LIMIT_OFS: begin
          if (st_reg.w_strb[0]) begin
            st_next.mid_limit_value = (wbyte > throttle_pkg::LIMIT_MAX) ?
                                      throttle_pkg::LIMIT_MAX : wbyte;
          end
        end
        throttle_pkg::GLOBAL_LIMIT_OFS: begin
          if (st_reg.w_strb[0]) begin
            st_next.global_activation_limit = (wbyte > throttle_pkg::LIMIT_MAX) ?
                                              throttle_pkg::LIMIT_MAX : wbyte;
          end
        end
        throttle_pkg::CONTROL_OFS: begin
          if (st_reg.w_strb[0]) begin
            st_next.thermal_hunt_enable = wbyte[throttle_pkg::CTRL_HUNT_BIT];
            st_next.global_window_debug_select = wbyte[throttle_pkg::CTRL_DEBUG_BIT];
          end
        end
        throttle_pkg::IRQ_STATUS_OFS: begin
          if (st_reg.w_strb[0]) begin
            st_next.irq_status = st_reg.irq_status & ~wbyte[1:0];
          end
        end
        throttle_pkg::IRQ_MASK_OFS: begin
          if (st_reg.w_strb[0]) begin
            st_next.irq_mask = wbyte[1:0];
          end
        end
        throttle_pkg::STATUS_OFS: begin
          st_next.bresp = throttle_pkg::RESP_OKAY;
        end
        default: begin
          st_next.bresp = throttle_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // New events win over a clear in the same cycle
    st_next.irq_status = st_next.irq_status | irq_set;
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);

    // Read channel
    if (st_reg.arready && s_axi_arvalid_i) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = throttle_pkg::RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      case ({s_axi_araddr_i[7:2], 2'h0})
        throttle_pkg::LOW_LIMIT_OFS: begin
          st_next.rdata[7:0] = st_reg.low_limit_value;
        end
        throttle_pkg::STATUS_OFS: begin
          st_next.rdata[7:0] = st_reg.current_throttle_value;
          st_next.rdata[throttle_pkg::STS_GLOBAL_BIT] = st_reg.global_throttle_active;
        end
        throttle_pkg::CONTROL_OFS: begin
          st_next.rdata[throttle_pkg::CTRL_HUNT_BIT] = st_reg.thermal_hunt_enable;
          st_next.rdata[throttle_pkg::CTRL_DEBUG_BIT] = st_reg.global_window_debug_select;
        end
        throttle_pkg::GLOBAL_LIMIT_OFS: begin
          st_next.rdata[7:0] = st_reg.global_activation_limit;
        end
        throttle_pkg::MID_LIMIT_OFS: begin
          st_next.rdata[7:0] = st_reg.mid_limit_value;
        end
        throttle_pkg::IRQ_STATUS_OFS: begin
          st_next.rdata[1:0] = st_reg.irq_status;
        end
        throttle_pkg::IRQ_MASK_OFS: begin
          st_next.rdata[1:0] = st_reg.irq_mask;
        end
        default: begin
          st_next.rresp = throttle_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.low_limit_value <= throttle_pkg::LIMIT_RESET;
      st_reg.mid_limit_value <= throttle_pkg::LIMIT_RESET;
      st_reg.global_activation_limit <= throttle_pkg::LIMIT_RESET;
      st_reg.irq_status <= throttle_pkg::IRQ_RESET;
      st_reg.irq_mask <= throttle_pkg::IRQ_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o = st_reg.wready;
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_bresp_o = st_reg.bresp;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign s_axi_rdata_o = st_reg.rdata;
  assign s_axi_rresp_o = st_reg.rresp;
  assign act_grant_o = st_reg.grant;
  assign global_throttle_active_o = st_reg.global_throttle_active;
  assign irq_o = st_reg.irq;

endmodule

// [verif/throttle_chk.sv]
/*
  Port-level assertions for the activation throttle.
  Assumes it is bound to every dram_activation_throttle instance.
*/
`timescale 1ns/1ps
module throttle_chk #(
  parameter int unsigned NUM_PAIRS = 2
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 s_axi_awvalid_i,
  input wire logic                 s_axi_awready_o,
  input wire logic                 s_axi_wvalid_i,
  input wire logic                 s_axi_wready_o,
  input wire logic [1:0]           s_axi_bresp_o,
  input wire logic                 s_axi_bvalid_o,
  input wire logic                 s_axi_bready_i,
  input wire logic [7:0]           s_axi_araddr_i,
  input wire logic                 s_axi_arvalid_i,
  input wire logic                 s_axi_arready_o,
  input wire logic [31:0]          s_axi_rdata_o,
  input wire logic                 s_axi_rvalid_o,
  input wire logic                 s_axi_rready_i,
  input wire logic [NUM_PAIRS-1:0] act_req_i,
  input wire logic [NUM_PAIRS-1:0] act_grant_o
);
  logic [7:0] rd_addr_reg;
  // Needed to know which register a read answer belongs to
  always_ff @(posedge clk_i) begin
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rd_addr_reg <= s_axi_araddr_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_take_s;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence b_late_s;
    !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endsequence
  write_answer_a: assert property (wr_take_s |=> b_late_s)
    else $error("Write response not two cycles after take");
  b_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("Write response dropped early");
  r_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("Read data dropped early");
  write_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("Write accepted while response pending");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("Read answer not one cycle after take");
  upper_zero_a: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:9] == 23'h00_0000)
    else $error("Read data upper bits not zero");
  limit_cap_a: assert property (
    s_axi_rvalid_o && (rd_addr_reg == throttle_pkg::LOW_LIMIT_OFS ||
    rd_addr_reg == throttle_pkg::STATUS_OFS) |->
    s_axi_rdata_o[7:0] <= throttle_pkg::LIMIT_MAX)
    else $error("Throttle value above cap");
  grant_cause_a: assert property ((act_grant_o & ~$past(act_req_i)) == '0)
    else $error("Grant without request");
endmodule

bind dram_activation_throttle throttle_chk #(.NUM_PAIRS(NUM_PAIRS)) throttle_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .act_req_i(act_req_i), .act_grant_o(act_grant_o));

// [verif/act_sink.sv]
/*
  Memory module pairs: count the activates that reach them.
  Assumes one grant pulse per activate, on the same clock.
*/
`timescale 1ns/1ps
module act_sink #(
  parameter int unsigned NUM_PAIRS = 2
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 clear_i,
  input  wire logic [NUM_PAIRS-1:0] grant_i,
  output logic [15:0]               count_o [NUM_PAIRS]
);
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (rst_i || clear_i) begin
        count_o[p] <= 16'h0000;
      end else if (grant_i[p]) begin
        count_o[p] <= count_o[p] + 16'h0001;
      end
    end
  end
endmodule

// [verif/testbench.sv]
/*
  Self-checking bench for the activation throttle.
  Assumes short windows: 64 normal, 40 debug, 8 per activation window.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [31:0] wd; logic [7:0] ex;} row_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, clr = 1'b0, awready, wready, bvalid;
  logic        arready, rvalid, flag, irq;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdv;
  logic [1:0]  bresp, rresp, rs, temp = 2'h0;
  logic [1:0]  req = 2'h0, grant;
  logic [3:0]  wstrb = 4'hF;
  logic [15:0] cnt [2];
  int          miscompares = 0, check_count = 0;
  row_t        rows [5] = '{'{32'h0000_0000, 8'h00}, '{32'h0000_0001, 8'h01},
    '{32'h0000_00A8, 8'hA8}, '{32'h0000_00A9, 8'hA8}, '{32'h0000_12FF, 8'hA8}};
  always #5 clk_i = ~clk_i;
  dram_activation_throttle #(.NUM_PAIRS(2), .GLB_WINDOW_LEN(64), .GLB_DEBUG_LEN(40),
    .ACT_WINDOW_LEN(8)) dram_activation_throttle_inst (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .temp_range_i(temp), .act_req_i(req), .act_grant_o(grant),
    .global_throttle_active_o(flag), .irq_o(irq));
  act_sink #(.NUM_PAIRS(2)) act_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .clear_i(clr),
    .grant_i(grant), .count_o(cnt));
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ad, dd;
    n = 0; ad = 1'b0; dd = 1'b0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ad && dd) && n < 100) begin
      @(posedge clk_i); n++;
      if (!ad && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!dd && wready === 1'b1) begin dd = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do begin @(posedge clk_i); n++; end while (bvalid !== 1'b1 && n < 200);
    r = bresp; bready <= 1'b0;
    if (n >= 200) miscompares++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1;
    do begin @(posedge clk_i); n++; end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin @(posedge clk_i); n++; end while (rvalid !== 1'b1 && n < 200);
    d = rdata; r = rresp; rready <= 1'b0;
    if (n >= 200) miscompares++;
  endtask
  task automatic wait_flag(input logic v, input int lim);
    for (int i = 0; i < lim && flag !== v; i++) @(posedge clk_i);
  endtask
  task automatic drive(input int n);
    clr <= 1'b1; @(posedge clk_i); clr <= 1'b0; req <= 2'h1;
    repeat (n) @(posedge clk_i);
    req <= 2'h0; repeat (3) @(posedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(throttle_pkg::LOW_LIMIT_OFS, rdv, rs); chk("low reset", 32'h0000_0000, rdv);
    rd(throttle_pkg::STATUS_OFS, rdv, rs); chk("status reset", 32'h0000_0000, rdv);
    rd(throttle_pkg::IRQ_STATUS_OFS, rdv, rs); chk("irq reset", 32'h0000_0000, rdv);
    rd(8'h00, rdv, rs); chk("unmapped resp", 32'(throttle_pkg::RESP_SLVERR), 32'(rs));
    wr(throttle_pkg::STATUS_OFS, 32'h0000_01FF, rs); chk("ro resp", 32'h0000_0000, 32'(rs));
    rd(throttle_pkg::STATUS_OFS, rdv, rs); chk("status ro", 32'h0000_0000, rdv);
    $display("TEST reset and access done");
    foreach (rows[i]) begin
      wr(throttle_pkg::LOW_LIMIT_OFS, rows[i].wd, rs);
      rd(throttle_pkg::LOW_LIMIT_OFS, rdv, rs);
      chk("low limit", 32'(rows[i].ex), rdv);
      rd(throttle_pkg::STATUS_OFS, rdv, rs);
      chk("status value", 32'(rows[i].ex), rdv);
    end
    wstrb <= 4'h0;
    wr(throttle_pkg::LOW_LIMIT_OFS, 32'h0000_0002, rs);
    wstrb <= 4'hF;
    rd(throttle_pkg::LOW_LIMIT_OFS, rdv, rs); chk("strobe off", 32'h0000_00A8, rdv);
    $display("TEST limit table done");
    wr(throttle_pkg::MID_LIMIT_OFS, 32'h0000_0003, rs);
    wr(throttle_pkg::LOW_LIMIT_OFS, 32'h0000_0005, rs);
    wr(throttle_pkg::CONTROL_OFS, 32'h0000_0001, rs);
    temp <= throttle_pkg::TEMP_LOW;
    rd(throttle_pkg::STATUS_OFS, rdv, rs); chk("hunt low", 32'h0000_0005, rdv);
    temp <= throttle_pkg::TEMP_MID;
    @(posedge clk_i);
    rd(throttle_pkg::STATUS_OFS, rdv, rs); chk("hunt mid", 32'h0000_0003, rdv);
    wr(throttle_pkg::CONTROL_OFS, 32'h0000_0000, rs);
    rd(throttle_pkg::STATUS_OFS, rdv, rs); chk("no hunt mid", 32'h0000_0005, rdv);
    $display("TEST selection done");
    wr(throttle_pkg::LOW_LIMIT_OFS, 32'h0000_0000, rs);
    drive(16); chk("unlimited grants", 32'h0000_0010, {16'h0000, cnt[0]});
    wr(throttle_pkg::LOW_LIMIT_OFS, 32'h0000_0001, rs);
    drive(16); chk("limited grants", 32'h0000_0001, 32'(cnt[0] >= 4 && cnt[0] <= 12));
    $display("TEST activate blocking done");
    wr(throttle_pkg::LOW_LIMIT_OFS, 32'h0000_0000, rs);
    wr(throttle_pkg::MID_LIMIT_OFS, 32'h0000_0002, rs);
    wr(throttle_pkg::GLOBAL_LIMIT_OFS, 32'h0000_0001, rs);
    wr(throttle_pkg::IRQ_MASK_OFS, 32'h0000_0003, rs);
    wr(throttle_pkg::CONTROL_OFS, 32'h0000_0002, rs);
    drive(90); chk("flag engaged", 32'h0000_0001, 32'(flag));
    rd(throttle_pkg::STATUS_OFS, rdv, rs);
    chk("global status", 32'h0000_0102, rdv);
    chk("irq engaged", 32'h0000_0001, 32'(irq));
    wr(throttle_pkg::IRQ_MASK_OFS, 32'h0000_0000, rs);
    wr(throttle_pkg::IRQ_STATUS_OFS, 32'h0000_0003, rs);
    wr(throttle_pkg::IRQ_MASK_OFS, 32'h0000_0003, rs);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    wr(throttle_pkg::CONTROL_OFS, 32'h0000_0000, rs);
    repeat (750) @(posedge clk_i);
    chk("flag held normal", 32'h0000_0001, 32'(flag));
    wait_flag(1'b0, 600); chk("flag released", 32'h0000_0000, 32'(flag));
    @(posedge clk_i); chk("irq release", 32'h0000_0001, 32'(irq));
    wr(throttle_pkg::CONTROL_OFS, 32'h0000_0002, rs);
    drive(90); chk("flag again", 32'h0000_0001, 32'(flag));
    repeat (25) @(posedge clk_i);
    chk("flag held debug", 32'h0000_0001, 32'(flag));
    wait_flag(1'b0, 150); chk("debug release", 32'h0000_0000, 32'(flag));
    $display("TEST global throttle done");
    finish_test();
  end
endmodule
